// ==== include/acr_pkg.sv ====
// Functional notes
// RULE1 - Conversion timed internally, typically 0.70 us, never beyond 0.75 us.
// RULE2 - Acquisition completes within 150 ns before the next start is accepted.
// RULE3 - Conversion plus acquisition fits 800 ns, at least 1.25 Msps.
// RULE4 - Light shutdown keeps only logic and reference powered.
// RULE5 - Ready for conversion 200 ns after leaving light shutdown.
// RULE6 - Host waits 10 ms after deep shutdown before starting conversions.
// RULE7 - Shutdown while power_down_n low, operational while high. The code does not shut down in CONV or ACQ; it waits for them to end.
// RULE8 - light_vs_deep_select high picks light, low picks deep shutdown.
// RULE9 - Host sets the select level before lowering power_down_n.
// RULE10 - Low start input with chip select low begins a conversion.
// RULE11 - Start requests during a running conversion are ignored.
// RULE12 - Busy low for the whole conversion, high when complete.
// RULE13 - Chip select and read low keep data driven; valid at busy rise.
// RULE14 - Data outputs released except while read strobe is low.
// RULE15 - Slow memory: low strobe starts conversion, previous result shown meanwhile.
// RULE16 - Slow memory: new result presented before busy rises.
// RULE17 - Slow memory: host holds strobe low until busy rises, then reads.
// RULE18 - ROM mode: each strobe pulse reads previous result and starts a new one.
// RULE19 - Host should stall or isolate its bus during conversions.
// RULE20 - Result is 12-bit straight binary, one step per 1/4096 of full scale.
// RULE21 - Last result held unchanged until the next conversion completes.
package acr_pkg;
	localparam int        CLK_PERIOD_NS   = 8;
	localparam int        DATA_WIDTH      = 12;
	localparam int        CONV_TIME_NS    = 700;
	localparam int        ACQ_TIME_NS     = 150;
	localparam int        NAP_WAKE_NS     = 200;
	localparam int        SLEEP_WAKE_MS   = 10;
	// Typical conversion rounded down keeps it inside the 750 ns limit
	localparam int        CONV_CYCLES     = CONV_TIME_NS / CLK_PERIOD_NS;
	localparam int        THROUGHPUT_NS   = 800;
	localparam int        THROUGHPUT_CYC  = THROUGHPUT_NS / CLK_PERIOD_NS;
	// Acquisition spans the ACQ state plus the idle cycle that takes the next
	// start, so a full sample fits the throughput and stays under ACQ_TIME_NS
	localparam int        ACQ_CYCLES      = THROUGHPUT_CYC - CONV_CYCLES - 1;
	localparam int        NAP_WAKE_CYCLES = (NAP_WAKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int        SLEEP_WAKE_CYC  = SLEEP_WAKE_MS * 1000000 / CLK_PERIOD_NS;
	localparam int        CNT_WIDTH       = 24;
	localparam logic [11:0] RESULT_RESET  = 12'h000;

	typedef enum logic [4:0] {
		ACR_OFF   = 5'h01,
		ACR_WAKE  = 5'h02,
		ACR_IDLE  = 5'h04,
		ACR_CONV  = 5'h08,
		ACR_ACQ   = 5'h10
	} acr_state_t;
endpackage : acr_pkg

// ==== include/acr_sample_if.sv ====
`timescale 1ns/100ps
interface acr_sample_if;
	logic                                   take;
	logic [acr_pkg::DATA_WIDTH-1:0]         sample;
	logic [acr_pkg::DATA_WIDTH-1:0]         result;
	modport ctrl (output take, output sample, input result);
	modport store (input take, input sample, output result);
endinterface : acr_sample_if

// ==== logic/acr_result_store.sv ====
`timescale 1ns/100ps
module acr_result_store (
	// Clock and reset
	input  wire logic  sys_clk,
	input  wire logic  reset_n,
	// Sample path
	acr_sample_if.store port
);
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			port.result <= acr_pkg::RESULT_RESET;
		end else if (port.take) begin
			port.result <= port.sample; // [RULE21]
		end
	end
endmodule : acr_result_store

// ==== logic/adc_conversion_read_control.sv ====
`timescale 1ns/100ps
module adc_conversion_read_control #(
	parameter int SLEEP_WAKE_CYCLES = acr_pkg::SLEEP_WAKE_CYC
) (
	// Clock and reset
	input  wire logic                         sys_clk,
	input  wire logic                         reset_n,
	// Host control pins
	input  wire logic                         conversion_start_n,
	input  wire logic                         chip_select_n,
	input  wire logic                         read_n,
	input  wire logic                         power_down_n,
	input  wire logic                         light_vs_deep_select,
	// Converter core
	input  wire logic [acr_pkg::DATA_WIDTH-1:0] core_code,
	output logic                              core_sample,
	output logic                              bias_enable,
	output logic                              reference_enable,
	// Status and data
	output logic                              busy_n,
	output logic [acr_pkg::DATA_WIDTH-1:0]    data_out,
	output logic                              data_oe
);
	// ****************************************
	// Pin synchronisers
	// ****************************************
	logic [4:0] pinMeta_reg;
	logic [4:0] pinSync_reg;
	logic       startPrev_reg;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			pinMeta_reg <= 5'h1f;
			pinSync_reg <= 5'h1f;
		end else begin
			pinMeta_reg <= {conversion_start_n, chip_select_n, read_n,
				power_down_n, light_vs_deep_select};
			pinSync_reg <= pinMeta_reg;
		end
	end
	logic startN;
	logic csN;
	logic rdN;
	logic pdN;
	logic lightSel;
	assign startN   = pinSync_reg[4];
	assign csN      = pinSync_reg[3];
	assign rdN      = pinSync_reg[2];
	assign pdN      = pinSync_reg[1];
	assign lightSel = pinSync_reg[0];

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			startPrev_reg <= 1'b1;
		end else begin
			startPrev_reg <= startN;
		end
	end
	logic startFall;
	assign startFall = startPrev_reg && !startN && !csN; // [RULE10]

	// ****************************************
	// Sequencer
	// ****************************************
	acr_pkg::acr_state_t          state_reg;
	acr_pkg::acr_state_t          state_next;
	logic [acr_pkg::CNT_WIDTH-1:0] count_reg;
	logic [acr_pkg::CNT_WIDTH-1:0] count_next;
	logic                          lightMode_reg;
	logic                          take;

	typedef logic [acr_pkg::CNT_WIDTH-1:0] acr_count_t;

	// Bias stays on in every state but OFF, in light and deep shutdown alike
	function automatic logic acr_is_powered(input acr_pkg::acr_state_t s);
		acr_is_powered = (s != acr_pkg::ACR_OFF);
	endfunction : acr_is_powered

	// A conversion begins on the edge that moves the sequencer into CONV
	function automatic logic acr_enters_conv(input acr_pkg::acr_state_t cur,
		input acr_pkg::acr_state_t nxt);
		acr_enters_conv = (nxt == acr_pkg::ACR_CONV) && (cur != acr_pkg::ACR_CONV);
	endfunction : acr_enters_conv

	always_comb begin
		state_next = state_reg;
		count_next = count_reg;
		take       = 1'b0;
		case (state_reg)
			acr_pkg::ACR_OFF: begin
				if (pdN) begin
					state_next = acr_pkg::ACR_WAKE;
					// Deep shutdown must let the reference settle again
					count_next = lightMode_reg ? acr_count_t'(acr_pkg::NAP_WAKE_CYCLES - 1)
						: acr_count_t'(SLEEP_WAKE_CYCLES - 1); // [RULE5]
				end
			end
			acr_pkg::ACR_WAKE: begin
				if (!pdN) begin
					state_next = acr_pkg::ACR_OFF;
				end else if (count_reg == '0) begin
					state_next = acr_pkg::ACR_IDLE;
				end else begin
					count_next = count_reg - 1'b1;
				end
			end
			acr_pkg::ACR_IDLE: begin
				if (!pdN) begin
					state_next = acr_pkg::ACR_OFF; // [RULE7]
				end else if (startFall) begin
					state_next = acr_pkg::ACR_CONV;
					count_next = acr_count_t'(acr_pkg::CONV_CYCLES - 1); // [RULE1]
				end
			end
			acr_pkg::ACR_CONV: begin
				// Starts are not looked at here, so a second request is dropped
				if (count_reg == '0) begin // [RULE11]
					take       = 1'b1;
					state_next = acr_pkg::ACR_ACQ;
					count_next = acr_count_t'(acr_pkg::ACQ_CYCLES - 1); // [RULE2]
				end else begin
					count_next = count_reg - 1'b1;
				end
			end
			acr_pkg::ACR_ACQ: begin
				// Conversion, acquisition and the accepting idle cycle fill 800 ns
				if (count_reg == '0) begin // [RULE3]
					state_next = acr_pkg::ACR_IDLE;
				end else begin
					count_next = count_reg - 1'b1;
				end
			end
			default: begin
				state_next = acr_pkg::ACR_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			state_reg <= acr_pkg::ACR_IDLE;
			count_reg <= '0;
		end else begin
			state_reg <= state_next;
			count_reg <= count_next;
		end
	end

	// Shutdown type follows the select pin until shutdown takes effect, then
	// stays frozen so a late select change cannot swap modes mid-shutdown
	logic lightMode_next;
	always_comb begin
		lightMode_next = lightMode_reg;
		if (acr_is_powered(state_reg)) begin
			lightMode_next = lightSel; // [RULE8] [RULE9]
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			lightMode_reg <= 1'b1;
		end else begin
			lightMode_reg <= lightMode_next;
		end
	end

	// ****************************************
	// Power controls
	// ****************************************
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			bias_enable      <= 1'b1;
			reference_enable <= 1'b1;
		end else begin
			bias_enable      <= acr_is_powered(state_next); // [RULE4]
			// Uses the type frozen on this same edge, so no one-cycle glitch
			reference_enable <= acr_is_powered(state_next) || lightMode_next; // [RULE4]
		end
	end

	// ****************************************
	// Result and data port
	// ****************************************
	acr_sample_if sampleBus ();
	assign sampleBus.take   = take;
	assign sampleBus.sample = core_code; // [RULE20]

	acr_result_store u_store (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.port    (sampleBus)
	);

	// Result register loads on take, data_out follows one edge later and
	// busy_n rises one edge after that, so the new code already stands
	logic takeDly_reg;
	logic dataNew_reg;
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			takeDly_reg <= 1'b0;
			dataNew_reg <= 1'b0;
		end else begin
			takeDly_reg <= take;
			dataNew_reg <= takeDly_reg;
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			core_sample <= 1'b0;
		end else begin
			core_sample <= acr_enters_conv(state_reg, state_next); // [RULE10]
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			data_out <= acr_pkg::RESULT_RESET;
			data_oe  <= 1'b0;
		end else begin
			data_out <= sampleBus.result; // [RULE15] [RULE16] [RULE18]
			data_oe  <= !csN && !rdN; // [RULE13] [RULE14]
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			busy_n <= 1'b1;
		end else if (acr_enters_conv(state_reg, state_next)) begin
			busy_n <= 1'b0; // [RULE12]
		end else if (dataNew_reg) begin
			busy_n <= 1'b1; // [RULE12] [RULE16]
		end
	end
endmodule : adc_conversion_read_control

// ==== dv/acr_checker_asserts.sv ====
`timescale 1ns/100ps
module acr_checker #(
	parameter int SLEEP_WAKE_CYCLES = 20
) (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        reset_n,
	// Host pins
	input wire logic        conversion_start_n,
	input wire logic        chip_select_n,
	input wire logic        read_n,
	input wire logic        power_down_n,
	input wire logic        light_vs_deep_select,
	// Core and status
	input wire logic [11:0] core_code,
	input wire logic        core_sample,
	input wire logic        bias_enable,
	input wire logic        reference_enable,
	input wire logic        busy_n,
	input wire logic [11:0] data_out,
	input wire logic        data_oe
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	property p_conv; $fell(busy_n) |-> ##[88:90] $rose(busy_n); endproperty
	a_conv: assert property (p_conv) else $error("busy low time off");
	property p_cause; $fell(busy_n) |-> !$past(conversion_start_n, 3); endproperty
	a_cause: assert property (p_cause) else $error("busy fell without start");
	property p_hold; !$stable(data_out) |=> $rose(busy_n); endproperty
	a_hold: assert property (p_hold) else $error("result moved off cycle");
	property p_rdy; $rose(busy_n) |-> $stable(data_out); endproperty
	a_rdy: assert property (p_rdy) else $error("result late at busy rise");
	property p_oe; (!chip_select_n && !read_n) [*4] |-> data_oe; endproperty
	a_oe: assert property (p_oe) else $error("data not driven");
	property p_hiz; read_n [*4] |-> !data_oe; endproperty
	a_hiz: assert property (p_hiz) else $error("data driven while idle");
	property p_pd; $fell(bias_enable) |-> !power_down_n; endproperty
	a_pd: assert property (p_pd) else $error("shutdown without request");
	property p_deep; $fell(reference_enable) |-> !light_vs_deep_select; endproperty
	a_deep: assert property (p_deep) else $error("reference off in light mode");
	property p_smp; $fell(busy_n) |-> core_sample; endproperty
	a_smp: assert property (p_smp) else $error("no core sample at conversion start");
	c_conv: cover property ($rose(busy_n));
	c_nap: cover property ($fell(bias_enable) && reference_enable);
	c_sleep: cover property ($fell(reference_enable));
endmodule : acr_checker

bind adc_conversion_read_control acr_checker #(.SLEEP_WAKE_CYCLES(SLEEP_WAKE_CYCLES)) i_chk (
	.sys_clk, .reset_n, .conversion_start_n, .chip_select_n, .read_n, .power_down_n,
	.light_vs_deep_select, .core_code, .core_sample, .bias_enable, .reference_enable,
	.busy_n, .data_out, .data_oe);

// ==== dv/acr_core_model.sv ====
`timescale 1ns/100ps
module acr_core_model (
	// Clock and reset
	input wire logic        sys_clk,
	input wire logic        reset_n,
	// Core side
	input wire logic        core_sample,
	output logic [11:0]     core_code
);
	// A new code per sample, so a stray extra sample shows in the result
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) core_code <= 12'h5a5;
		else if (core_sample) core_code <= core_code + 12'h111;
	end
endmodule : acr_core_model

// ==== dv/adc_conversion_read_control_test.sv ====
`timescale 1ns/100ps
module adc_conversion_read_control_test;
	logic        sys_clk = 1'b0;
	logic        reset_n = 1'b0;
	logic        conversion_start_n = 1'b1;
	logic        chip_select_n = 1'b0;
	logic        read_n = 1'b0;
	logic        power_down_n = 1'b1;
	logic        light_vs_deep_select = 1'b1;
	logic [11:0] core_code, data_out, expData;
	logic        core_sample, bias_enable, reference_enable, busy_n, data_oe;
	wire  [11:0] dataBus = data_oe ? data_out : 12'hzzz;
	int          fail_count = 0;
	int          checks = 0;
	always #4 sys_clk = ~sys_clk;
	acr_core_model i_core (.sys_clk, .reset_n, .core_sample, .core_code);
	adc_conversion_read_control #(.SLEEP_WAKE_CYCLES(20)) i_dut (.sys_clk, .reset_n,
		.conversion_start_n, .chip_select_n, .read_n, .power_down_n, .light_vs_deep_select,
		.core_code, .core_sample, .bias_enable, .reference_enable, .busy_n, .data_out, .data_oe);
	task automatic chk(input logic [11:0] seen, input logic [11:0] want);
		checks++;
		if (seen !== want) begin
			fail_count++;
			$display("ERROR %0t seen %h expected %h", $time, seen, want);
		end
	endtask : chk
	task automatic tally_and_finish;
		if (fail_count == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : tally_and_finish
	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : idle
	// Tie joins read to start, as in slow memory and ROM wiring
	task automatic convert(input bit tie);
		int n;
		@(posedge sys_clk) conversion_start_n <= 1'b0;
		if (tie) read_n <= 1'b0;
		idle(6);
		chk({11'h0, busy_n}, 12'h000);
		if (tie) chk(dataBus, expData);
		if (!tie) @(posedge sys_clk) conversion_start_n <= 1'b1;
		idle(3);
		if (!tie) @(posedge sys_clk) conversion_start_n <= 1'b0;
		n = 0;
		while (busy_n !== 1'b1 && n < 120) begin
			@(negedge sys_clk);
			n++;
		end
		chk({11'h0, n <= 88}, 12'h001);
		expData = expData + 12'h111;
		chk(data_out, expData);
		@(posedge sys_clk) conversion_start_n <= 1'b1;
		if (tie) read_n <= 1'b1;
		idle(20);
	endtask : convert
	task automatic shared_bus;
		@(posedge sys_clk) read_n <= 1'b1;
		convert(1'b0);
		chk(dataBus, 12'hzzz);
		@(posedge sys_clk) read_n <= 1'b0;
		idle(5);
		chk(dataBus, expData);
		idle(9);
		chk(dataBus, expData);
	endtask : shared_bus
	// Second start pin fall lands exactly one throughput period after the first
	task automatic back_to_back;
		@(posedge sys_clk) conversion_start_n <= 1'b0;
		idle(50);
		@(posedge sys_clk) conversion_start_n <= 1'b1;
		idle(50);
		chk({11'h0, busy_n}, 12'h001);
		@(posedge sys_clk) conversion_start_n <= 1'b0;
		idle(6);
		chk({11'h0, busy_n}, 12'h000);
		@(posedge sys_clk) conversion_start_n <= 1'b1;
		idle(100);
		expData = expData + 12'h222;
		chk(data_out, expData);
	endtask : back_to_back
	task automatic shut_down(input logic light);
		@(posedge sys_clk) light_vs_deep_select <= light;
		idle(2);
		@(posedge sys_clk) power_down_n <= 1'b0;
		idle(8);
		chk({10'h0, bias_enable, reference_enable}, {11'h0, light});
		@(posedge sys_clk) conversion_start_n <= 1'b0;
		idle(8);
		chk({11'h0, busy_n}, 12'h001);
		@(posedge sys_clk) conversion_start_n <= 1'b1;
		power_down_n <= 1'b1;
		idle(12);
		chk({10'h0, bias_enable, reference_enable}, 12'h003);
		if (light) begin
			// A start inside the light wake-up span must be refused
			@(posedge sys_clk) conversion_start_n <= 1'b0;
			idle(8);
			chk({11'h0, busy_n}, 12'h001);
			@(posedge sys_clk) conversion_start_n <= 1'b1;
		end
		idle(20);
		convert(1'b0);
	endtask : shut_down
	initial begin
		expData = 12'h5a5;
		repeat (8) @(posedge sys_clk);
		reset_n <= 1'b1;
		idle(5);
		chk(dataBus, 12'h000);
		convert(1'b0);
		convert(1'b0);
		shared_bus;
		back_to_back;
		convert(1'b1);
		shut_down(1'b1);
		shut_down(1'b0);
		tally_and_finish;
	end
	initial begin
		#20000;
		fail_count++;
		tally_and_finish;
	end
endmodule : adc_conversion_read_control_test
